// *** sgp_map.svh ***
// Register map, field positions, reset values and timing figures
`ifndef SGP_MAP_SVH
`define SGP_MAP_SVH

// Register offsets
`define SGP_OFS_LEN_BUF        8'h04
`define SGP_OFS_STORM_HOST     8'h06
`define SGP_OFS_PRIO_MAP       8'h0C

// Frame length and buffer control fields
`define SGP_BIT_HUGE           2
`define SGP_BIT_LEGAL          1
`define SGP_BIT_RESERVE        0
`define SGP_LEN_BUF_RESET      16'h0000
`define SGP_LEN_BUF_WMASK      16'h0007

// Storm rate and host port control fields
`define SGP_RATE_HI_MSB        15
`define SGP_RATE_HI_LSB        8
`define SGP_BIT_HALF_DUPLEX    6
`define SGP_BIT_FLOW_CTRL      5
`define SGP_BIT_SPEED10        4
`define SGP_BIT_NULL_VID       3
`define SGP_RATE_LO_MSB        2
`define SGP_RATE_LO_LSB        0
`define SGP_STORM_HOST_RESET   16'h6320
`define SGP_STORM_HOST_WMASK   16'hFF7F

// Tag priority map
`define SGP_PRIO_MAP_RESET     16'hFA50

// Frame length limits in bytes
`define SGP_LEN_HUGE           11'h77C
`define SGP_LEN_TAGGED         11'h5F2
`define SGP_LEN_UNTAGGED       11'h5EE
`define SGP_LEN_DEFAULT        11'h600

// Buffers pre-allocated per port
`define SGP_BUFS_PER_PORT      6'h30

// Null identifier value
`define SGP_VID_NULL           12'h000

// Storm window, in ms, and the core clock rate in MHz
`define SGP_WIN_FAST_MS        67
`define SGP_WIN_SLOW_MS        670
`define SGP_CLK_MHZ            40
`define SGP_KHZ_PER_MHZ        1000

// Ingress ports watched by the storm limiter
`define SGP_NPORT              3

`endif

// *** sgp_pkg.sv ***
// Types shared by the switch global policy register bank
package sgp_pkg;
  typedef logic [7:0]  sgp_addr_t;
  typedef logic [15:0] sgp_word_t;
  typedef logic [10:0] sgp_len_t;
  typedef logic [10:0] sgp_rate_t;
  typedef logic [2:0]  sgp_tag_t;
  typedef logic [1:0]  sgp_prio_t;
  typedef logic [11:0] sgp_vid_t;
  typedef logic [24:0] sgp_win_t;
  typedef logic [5:0]  sgp_bufs_t;
endpackage : sgp_pkg

// *** sgp_policy_regs.sv ***
// Global frame policy registers and the per-frame policy decisions they drive
//
// Notes on behaviour
// [R1] Huge-frame bit set: accept frames up to 1916 bytes, legal check ignored.
// [R2] Huge clear, legal check set: drop tagged over 1522, untagged over 1518.
// [R3] Both clear: accept frames up to and including 1536 bytes.
// [R4] 48 buffers per port; reserve plus multiple queues keeps them for q3-q1.
// [R5] Eleven-bit storm rate caps 64-byte blocks per 67ms or 670ms window.
// [R6] Host-port half-duplex bit selects half duplex, clear gives full duplex.
// [R7] Host-port flow control bit, set after reset, enables pause flow control.
// [R8] Host-port speed bit: set is 10 Mb/s, clear is 100 Mb/s, clear after reset.
// [R9] Null-identifier bit set: replace a null identifier with the port default.
// [R10] Eight 2-bit map fields, tag 7 at bits 15-14 down to tag 0 at 1-0.
// [R11] Map resets to 11,11,10,10,01,01,00,00 for tags 7 down to 0.
// [R12] Writes affect frames whose ingress check starts after the write.
//
// Design decision made here: strobed register access.
`timescale 1ns/1ps
`include "sgp_map.svh"

module sgp_policy_regs #(
  parameter sgp_pkg::sgp_win_t WIN_FAST_CYC =
    25'(`SGP_WIN_FAST_MS * `SGP_KHZ_PER_MHZ * `SGP_CLK_MHZ),
  parameter sgp_pkg::sgp_win_t WIN_SLOW_CYC =
    25'(`SGP_WIN_SLOW_MS * `SGP_KHZ_PER_MHZ * `SGP_CLK_MHZ)
) (
  // Clock and reset
  input  wire logic                         core_clk,
  input  wire logic                         rst,
  // Register port
  input  wire sgp_pkg::sgp_addr_t           regAddr,
  input  wire sgp_pkg::sgp_word_t           regWdata,
  input  wire logic                         regWr,
  input  wire logic                         regRd,
  output sgp_pkg::sgp_word_t                regRdata,
  // Ingress frame check request
  input  wire logic                         frmValid,
  input  wire sgp_pkg::sgp_len_t            frmLen,
  input  wire logic                         frmTagged,
  input  wire sgp_pkg::sgp_tag_t            frmTagPrio,
  input  wire sgp_pkg::sgp_vid_t            frmVid,
  input  wire sgp_pkg::sgp_vid_t            portVid,
  // Ingress frame check answer
  output logic                              resValid,
  output logic                              resAccept,
  output sgp_pkg::sgp_prio_t                resPrio,
  output sgp_pkg::sgp_vid_t                 resVid,
  // Queue manager
  input  wire logic                         multiQueueOn,
  output sgp_pkg::sgp_bufs_t                bufsPerPort,
  output logic                              reserveHighOnly,
  // Broadcast storm limiter, one lane per ingress port
  input  wire logic [`SGP_NPORT-1:0]        stormBlkTick,
  input  wire logic [`SGP_NPORT-1:0]        portSpeed10,
  output logic [`SGP_NPORT-1:0]             stormLimit,
  // Host-side port MAC
  output logic                              hostHalfDuplex,
  output logic                              hostFlowCtrl,
  output logic                              hostSpeed10
);
  import sgp_pkg::*;

  // Register storage
  sgp_word_t lenBufReg;
  sgp_word_t stormHostReg;
  sgp_word_t tagPriorityMap;

  // Address decode
  wire       hitLenBuf    = (regAddr == `SGP_OFS_LEN_BUF);
  wire       hitStormHost = (regAddr == `SGP_OFS_STORM_HOST);
  wire       hitPrioMap   = (regAddr == `SGP_OFS_PRIO_MAP);
  wire       wrLenBuf     = regWr && hitLenBuf;
  wire       wrStormHost  = regWr && hitStormHost;
  wire       wrPrioMap    = regWr && hitPrioMap;

  // Unwritable bits keep their stored value
  wire sgp_word_t next_lenBufReg =
    (regWdata & `SGP_LEN_BUF_WMASK) | (lenBufReg & ~`SGP_LEN_BUF_WMASK);
  wire sgp_word_t next_stormHostReg =
    (regWdata & `SGP_STORM_HOST_WMASK) | (stormHostReg & ~`SGP_STORM_HOST_WMASK);

  // Read data, unmapped offsets read zero
  wire sgp_word_t next_regRdata =
    hitLenBuf    ? lenBufReg      :
    hitStormHost ? stormHostReg   :
    hitPrioMap   ? tagPriorityMap : 16'h0000;

  // Field views
  wire       cfgHuge       = lenBufReg[`SGP_BIT_HUGE];
  wire       cfgLegal      = lenBufReg[`SGP_BIT_LEGAL];
  wire       cfgReserve    = lenBufReg[`SGP_BIT_RESERVE];
  wire       cfgNullVid    = stormHostReg[`SGP_BIT_NULL_VID];
  wire sgp_rate_t cfgRate  = {stormHostReg[`SGP_RATE_LO_MSB:`SGP_RATE_LO_LSB],
                              stormHostReg[`SGP_RATE_HI_MSB:`SGP_RATE_HI_LSB]};

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      lenBufReg      <= `SGP_LEN_BUF_RESET;
      stormHostReg   <= `SGP_STORM_HOST_RESET;                         // [R7] [R8]
      tagPriorityMap <= `SGP_PRIO_MAP_RESET;                           // [R11]
    end
    else
    begin
      if (wrLenBuf)
        lenBufReg <= next_lenBufReg;
      if (wrStormHost)
        stormHostReg <= next_stormHostReg;
      if (wrPrioMap)
        tagPriorityMap <= regWdata;
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
      regRdata <= 16'h0000;
    else if (regRd)
      regRdata <= next_regRdata;
    else
      regRdata <= 16'h0000;
  end

  // Frame length limit; huge overrides the legal check
  wire sgp_len_t lenLimit =
    cfgHuge   ? `SGP_LEN_HUGE :                                        // [R1]
    cfgLegal  ? (frmTagged ? `SGP_LEN_TAGGED : `SGP_LEN_UNTAGGED) :    // [R2]
                `SGP_LEN_DEFAULT;                                      // [R3]
  wire       next_resAccept = (frmLen <= lenLimit);

  // Tag priority lookup, two bits per tag value
  wire sgp_prio_t next_resPrio =
    tagPriorityMap[{frmTagPrio, 1'b0} +: 2];                           // [R10]

  // Null identifier replacement
  wire sgp_vid_t next_resVid =
    (cfgNullVid && frmVid == `SGP_VID_NULL) ? portVid : frmVid;        // [R9]

  // Answer uses the settings held at the request edge, so a write in the
  // same cycle only reaches later frames
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      resValid  <= 1'b0;
      resAccept <= 1'b0;
      resPrio   <= 2'h0;
      resVid    <= 12'h000;
    end
    else
    begin
      resValid <= frmValid;
      if (frmValid)                                                    // [R12]
      begin
        resAccept <= next_resAccept;
        resPrio   <= next_resPrio;
        resVid    <= next_resVid;
      end
    end
  end

  // Queue manager and host port settings
  wire       next_reserveHighOnly = cfgReserve && multiQueueOn;

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      bufsPerPort     <= 6'h00;
      reserveHighOnly <= 1'b0;
      hostHalfDuplex  <= 1'b0;
      hostFlowCtrl    <= 1'b0;
      hostSpeed10     <= 1'b0;
    end
    else
    begin
      bufsPerPort     <= `SGP_BUFS_PER_PORT;                           // [R4]
      reserveHighOnly <= next_reserveHighOnly;                         // [R4]
      hostHalfDuplex  <= stormHostReg[`SGP_BIT_HALF_DUPLEX];           // [R6]
      hostFlowCtrl    <= stormHostReg[`SGP_BIT_FLOW_CTRL];             // [R7]
      hostSpeed10     <= stormHostReg[`SGP_BIT_SPEED10];               // [R8]
    end
  end

  // Storm limiter: counts 64-byte blocks per port within a timed window
  sgp_win_t  winCnt  [`SGP_NPORT];
  sgp_rate_t blkCnt  [`SGP_NPORT];

  genvar p;
  generate
    for (p = 0; p < `SGP_NPORT; p++)
    begin : g_storm
      wire sgp_win_t  winLen   = portSpeed10[p] ? WIN_SLOW_CYC : WIN_FAST_CYC;
      wire            winEnd   = (winCnt[p] >= winLen - 25'h0000001);
      wire            canCount = (blkCnt[p] != 11'h7FF);
      wire sgp_rate_t next_blk =
        winEnd ? 11'h000 : blkCnt[p] + 11'(stormBlkTick[p] && canCount);

      always_ff @(posedge core_clk)
      begin
        if (rst)
        begin
          winCnt[p]     <= 25'h0000000;
          blkCnt[p]     <= 11'h000;
          stormLimit[p] <= 1'b0;
        end
        else
        begin
          winCnt[p]     <= winEnd ? 25'h0000000 : winCnt[p] + 25'h0000001;
          blkCnt[p]     <= next_blk;                                   // [R5]
          stormLimit[p] <= (next_blk >= cfgRate);                      // [R5]
        end
      end
    end
  endgenerate

  // Checks
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (rst);

  property p_huge_limit;
    frmValid && cfgHuge |=> resAccept == ($past(frmLen) <= `SGP_LEN_HUGE);
  endproperty
  a_huge_limit: assert property (p_huge_limit)                          // [R1]
    else $error("huge frame limit wrong");

  property p_legal_limit;
    frmValid && !cfgHuge && cfgLegal |=>
      resAccept == ($past(frmTagged) ? ($past(frmLen) <= `SGP_LEN_TAGGED)
                                     : ($past(frmLen) <= `SGP_LEN_UNTAGGED));
  endproperty
  a_legal_limit: assert property (p_legal_limit)                        // [R2]
    else $error("legal length check wrong");

  property p_default_limit;
    frmValid && !cfgHuge && !cfgLegal |=>
      resAccept == ($past(frmLen) <= `SGP_LEN_DEFAULT);
  endproperty
  a_default_limit: assert property (p_default_limit)                    // [R3]
    else $error("default length limit wrong");

  property p_reserve;
    !rst |=> reserveHighOnly == $past(cfgReserve && multiQueueOn)
      && bufsPerPort == `SGP_BUFS_PER_PORT;
  endproperty
  a_reserve: assert property (p_reserve)                                // [R4]
    else $error("buffer reservation wrong");

  property p_storm_cause;
    $rose(stormLimit[0]) |-> $past(stormBlkTick[0]) || $past(cfgRate) != $past(cfgRate, 2)
      || $past(cfgRate) == 11'h000;
  endproperty
  a_storm_cause: assert property (p_storm_cause)                        // [R5]
    else $error("storm limit rose without a block");

  property p_half_duplex;
    wrStormHost |=> ##1 hostHalfDuplex == $past(regWdata[`SGP_BIT_HALF_DUPLEX], 2);
  endproperty
  a_half_duplex: assert property (p_half_duplex)                        // [R6]
    else $error("half duplex output wrong");

  property p_flow_ctrl;
    wrStormHost |=> ##1 hostFlowCtrl == $past(regWdata[`SGP_BIT_FLOW_CTRL], 2);
  endproperty
  a_flow_ctrl: assert property (p_flow_ctrl)                            // [R7]
    else $error("flow control output wrong");

  property p_speed;
    $fell(rst) |-> ##1 !hostSpeed10 && hostFlowCtrl;
  endproperty
  a_speed: assert property (disable iff (1'b0) p_speed)                 // [R8]
    else $error("host speed reset value wrong");

  property p_null_vid;
    frmValid && cfgNullVid && frmVid == `SGP_VID_NULL |=> resVid == $past(portVid);
  endproperty
  a_null_vid: assert property (p_null_vid)                              // [R9]
    else $error("null identifier not replaced");

  property p_prio_map;
    frmValid && !wrPrioMap ##1 !wrPrioMap |->
      resPrio == tagPriorityMap[{$past(frmTagPrio), 1'b0} +: 2];
  endproperty
  a_prio_map: assert property (p_prio_map)                              // [R10]
    else $error("priority lookup wrong");

  property p_map_reset;
    $fell(rst) |-> tagPriorityMap == `SGP_PRIO_MAP_RESET;
  endproperty
  a_map_reset: assert property (disable iff (1'b0) p_map_reset)         // [R11]
    else $error("priority map reset value wrong");

  property p_write_order;
    frmValid && wrLenBuf && !cfgHuge && !cfgLegal && regWdata[`SGP_BIT_HUGE] |=>
      resAccept == ($past(frmLen) <= `SGP_LEN_DEFAULT);
  endproperty
  a_write_order: assert property (p_write_order)                        // [R12]
    else $error("same-cycle write reached the frame");

  property p_speed_write;
    wrStormHost |=> ##1 hostSpeed10 == $past(regWdata[`SGP_BIT_SPEED10], 2);
  endproperty
  a_speed_write: assert property (p_speed_write)                        // [R8]
    else $error("host speed output wrong");

  property p_null_keep;
    frmValid && !(cfgNullVid && frmVid == `SGP_VID_NULL) |=> resVid == $past(frmVid);
  endproperty
  a_null_keep: assert property (p_null_keep)                            // [R9]
    else $error("identifier changed without need");

  property p_answer_pulse;
    !rst |=> resValid == $past(frmValid);
  endproperty
  a_answer_pulse: assert property (p_answer_pulse)                      // [R12]
    else $error("answer pulse wrong");

  property p_read_map;
    regRd && hitPrioMap |=> regRdata == $past(tagPriorityMap);
  endproperty
  a_read_map: assert property (p_read_map)                              // [R10]
    else $error("priority map read wrong");

  property p_map_write;
    wrPrioMap |=> tagPriorityMap == $past(regWdata);
  endproperty
  a_map_write: assert property (p_map_write)                            // [R10]
    else $error("priority map write lost");

  property p_storm_clear;
    g_storm[0].winEnd |=> stormLimit[0] == ($past(cfgRate) == 11'h000);
  endproperty
  a_storm_clear: assert property (p_storm_clear)                        // [R5]
    else $error("storm window end did not clear");

  c_huge_accept: cover property (frmValid && cfgHuge && frmLen > `SGP_LEN_DEFAULT
    ##1 resAccept);
  c_storm_hit: cover property ($rose(stormLimit[0]));
  c_null_swap: cover property (frmValid && cfgNullVid && frmVid == `SGP_VID_NULL);
  c_reserve: cover property ($rose(reserveHighOnly));
  c_map_write: cover property (wrPrioMap ##1 frmValid);

endmodule : sgp_policy_regs

// *** sgp_host_model.sv ***
// Host processor model driving the register port
`timescale 1ns/1ps

module sgp_host_model (
  // Clock
  input  wire logic            core_clk,
  // Register port
  output sgp_pkg::sgp_addr_t   regAddr,
  output sgp_pkg::sgp_word_t   regWdata,
  output logic                 regWr,
  output logic                 regRd,
  input  wire sgp_pkg::sgp_word_t regRdata
);
  import sgp_pkg::*;

  initial
  begin
    regAddr  = 8'h00;
    regWdata = 16'h0000;
    regWr    = 1'b0;
    regRd    = 1'b0;
  end

  task automatic wr(input sgp_addr_t a, input sgp_word_t d);
    @(posedge core_clk);
    regWr    <= 1'b1;
    regAddr  <= a;
    regWdata <= d;
    @(posedge core_clk);
    regWr    <= 1'b0;
    // Stale data is not left on the bus
    regWdata <= ~d;
  endtask : wr

  task automatic rd(input sgp_addr_t a, output sgp_word_t d);
    @(posedge core_clk);
    regRd   <= 1'b1;
    regAddr <= a;
    @(posedge core_clk);
    regRd   <= 1'b0;
    #1;
    d = regRdata;
  endtask : rd
endmodule : sgp_host_model

// *** sgp_tb.sv ***
// Self-checking bench for the global frame policy registers
`timescale 1ns/1ps

module testbench;
  import sgp_pkg::*;
  logic       core_clk;
  logic       rst;
  sgp_addr_t  regAddr;
  sgp_word_t  regWdata;
  logic       regWr;
  logic       regRd;
  sgp_word_t  regRdata;
  logic       frmValid;
  sgp_len_t   frmLen;
  logic       frmTagged;
  sgp_tag_t   frmTagPrio;
  sgp_vid_t   frmVid;
  sgp_vid_t   portVid;
  logic       resValid;
  logic       resAccept;
  sgp_prio_t  resPrio;
  sgp_vid_t   resVid;
  logic       multiQueueOn;
  sgp_bufs_t  bufsPerPort;
  logic       reserveHighOnly;
  logic [2:0] stormBlkTick;
  logic [2:0] portSpeed10;
  logic [2:0] stormLimit;
  logic       hostHalfDuplex;
  logic       hostFlowCtrl;
  logic       hostSpeed10;
  int         errors;
  int         comparisons;
  int         cyc;
  sgp_word_t  rv;
  sgp_word_t  maps [2] = '{16'hFA50, 16'h1B1B};
  int         ctl [9] = '{4, 4, 6, 2, 2, 2, 2, 0, 0};
  int         lens [9] = '{1916, 1917, 1916, 1522, 1523, 1518, 1519, 1536, 1537};
  logic       tags [9] = '{0, 1, 0, 1, 1, 0, 0, 1, 1};
  logic       acc [9] = '{1, 0, 1, 1, 0, 1, 0, 1, 0};

  sgp_host_model sgp_host_model_inst (.core_clk(core_clk), .regAddr(regAddr),
    .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata));

  sgp_policy_regs #(.WIN_FAST_CYC(25'd20), .WIN_SLOW_CYC(25'd200)) sgp_policy_regs_inst (
    .core_clk(core_clk), .rst(rst), .regAddr(regAddr), .regWdata(regWdata),
    .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .frmValid(frmValid),
    .frmLen(frmLen), .frmTagged(frmTagged), .frmTagPrio(frmTagPrio), .frmVid(frmVid),
    .portVid(portVid), .resValid(resValid), .resAccept(resAccept), .resPrio(resPrio),
    .resVid(resVid), .multiQueueOn(multiQueueOn), .bufsPerPort(bufsPerPort),
    .reserveHighOnly(reserveHighOnly), .stormBlkTick(stormBlkTick),
    .portSpeed10(portSpeed10), .stormLimit(stormLimit), .hostHalfDuplex(hostHalfDuplex),
    .hostFlowCtrl(hostFlowCtrl), .hostSpeed10(hostSpeed10));

  initial
  begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end

  always @(posedge core_clk) cyc <= rst ? 0 : cyc + 1;

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp, input string msg);
    comparisons++;
    if (seen !== exp)
    begin
      errors++;
      $display("wrong value at %0t: %s got %h expected %h", $time, msg, seen, exp);
    end
  endtask : chk

  task automatic rchk(input sgp_addr_t a, input sgp_word_t exp, input string msg);
    sgp_host_model_inst.rd(a, rv);
    chk(rv, exp, msg);
  endtask : rchk

  task automatic frm(input int len, input logic tg, input sgp_tag_t tp, input sgp_vid_t v,
                     input sgp_vid_t pv);
    @(posedge core_clk);
    frmValid   <= 1'b1;
    frmLen     <= sgp_len_t'(len);
    frmTagged  <= tg;
    frmTagPrio <= tp;
    frmVid     <= v;
    portVid    <= pv;
    @(posedge core_clk);
    frmValid   <= 1'b0;
    #1;
    chk({15'h0, resValid}, 16'h1, "answer pulse");
  endtask : frm

  task automatic settle;
    @(posedge core_clk);
    #1;
  endtask : settle

  task automatic close_out;
    $display("counts: %0d comparisons, %0d errors", comparisons, errors);
    if (errors == 0 && comparisons > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : close_out

  initial
  begin
    repeat (5000) @(posedge core_clk);
    errors++;
    close_out();
  end

  initial
  begin
    errors = 0;
    comparisons = 0;
    rst = 1'b1;
    frmValid = 1'b0;
    frmLen = 11'h000;
    frmTagged = 1'b0;
    frmTagPrio = 3'h0;
    frmVid = 12'h000;
    portVid = 12'h000;
    multiQueueOn = 1'b0;
    stormBlkTick = 3'h0;
    portSpeed10 = 3'h0;
    repeat (16) @(posedge core_clk);
    rst <= 1'b0;
    rchk(8'h04, 16'h0000, "length control reset");
    rchk(8'h06, 16'h6320, "storm host reset");
    rchk(8'h0C, 16'hFA50, "map reset");
    rchk(8'h08, 16'h0000, "unmapped read");
    chk({hostHalfDuplex, hostFlowCtrl, hostSpeed10}, 16'h2, "host reset");
    chk(bufsPerPort, 16'h30, "buffers per port");
    $display("test reset values done");
    for (int i = 0; i < 9; i++)
    begin
      sgp_host_model_inst.wr(8'h04, sgp_word_t'(ctl[i]));
      frm(lens[i], tags[i], 3'h0, 12'h001, 12'h001);
      chk(resAccept, acc[i], "length verdict");
    end
    fork
      sgp_host_model_inst.wr(8'h04, 16'h0004);
      frm(1600, 1'b0, 3'h0, 12'h001, 12'h001);
    join
    chk(resAccept, 16'h0, "old limit during write");
    frm(1600, 1'b0, 3'h0, 12'h001, 12'h001);
    chk(resAccept, 16'h1, "new limit after write");
    $display("test length limits done");
    for (int m = 0; m < 2; m++)
    begin
      if (m == 1)
        sgp_host_model_inst.wr(8'h0C, maps[1]);
      for (int t = 0; t < 8; t++)
      begin
        frm(64, 1'b1, sgp_tag_t'(t), 12'h001, 12'h001);
        chk(resPrio, (maps[m] >> (2 * t)) & 16'h3, "mapped priority");
      end
    end
    fork
      sgp_host_model_inst.wr(8'h0C, 16'hFA50);
      frm(64, 1'b1, 3'h0, 12'h001, 12'h001);
    join
    chk(resPrio, 16'h3, "old map during write");
    frm(64, 1'b1, 3'h0, 12'h001, 12'h001);
    chk(resPrio, 16'h0, "new map after write");
    $display("test priority map done");
    sgp_host_model_inst.wr(8'h06, 16'h00D8);
    settle();
    chk({hostHalfDuplex, hostFlowCtrl, hostSpeed10}, 16'h5, "host port bits");
    rchk(8'h06, 16'h0058, "storm host readback");
    frm(64, 1'b0, 3'h0, 12'h000, 12'h123);
    chk(resVid, 16'h123, "null replaced");
    frm(64, 1'b0, 3'h0, 12'h005, 12'h123);
    chk(resVid, 16'h005, "non-null kept");
    sgp_host_model_inst.wr(8'h06, 16'h6320);
    frm(64, 1'b0, 3'h0, 12'h000, 12'h123);
    chk(resVid, 16'h000, "null kept");
    settle();
    chk({hostHalfDuplex, hostFlowCtrl, hostSpeed10}, 16'h2, "host port back");
    $display("test host port and null identifier done");
    sgp_host_model_inst.wr(8'h04, 16'hFFFF);
    rchk(8'h04, 16'h0007, "length control mask");
    @(posedge core_clk);
    multiQueueOn <= 1'b1;
    settle();
    settle();
    chk(reserveHighOnly, 16'h1, "reserve with queues");
    @(posedge core_clk);
    multiQueueOn <= 1'b0;
    settle();
    settle();
    chk(reserveHighOnly, 16'h0, "reserve without queues");
    $display("test buffer reserve done");
    sgp_host_model_inst.wr(8'h06, 16'h0200);
    while (cyc % 20 != 8)
      @(posedge core_clk);
    stormBlkTick <= 3'h1;
    settle();
    chk(stormLimit, 16'h0, "one block");
    @(posedge core_clk);
    stormBlkTick <= 3'h0;
    #1;
    chk(stormLimit, 16'h1, "rate reached");
    repeat (8) @(posedge core_clk);
    #1;
    chk(stormLimit, 16'h1, "window still open");
    repeat (13) @(posedge core_clk);
    #1;
    chk(stormLimit, 16'h0, "window cleared");
    @(posedge core_clk);
    portSpeed10  <= 3'h2;
    stormBlkTick <= 3'h2;
    repeat (2) @(posedge core_clk);
    stormBlkTick <= 3'h0;
    repeat (30) @(posedge core_clk);
    #1;
    chk(stormLimit, 16'h2, "slow window holds");
    $display("test storm limit done");
    close_out();
  end
endmodule : testbench
